// file: logic/sdf_pkg.sv
// constants and types for the spindle drive and flex pin block
package sdf_pkg;
    // timebases
    localparam longint CLK_HZ = 50_000_000;
    localparam longint SPEED_N = 1;
    localparam longint PDM_HZ = 1_000_000;
    localparam longint PWM_MHZ = 22_050_000;
    localparam longint PLL_HZ = 4_230_000;
    localparam longint CDV_HZ_PER_D = 300;
    localparam int PDM_CYC = int'(CLK_HZ / (PDM_HZ * SPEED_N));
    localparam int PWM_CYC = int'(CLK_HZ * 1000 / (PWM_MHZ * SPEED_N));
    localparam int PLL_CYC = int'(CLK_HZ / (PLL_HZ * SPEED_N));
    localparam int CDV_CYC_DEF = int'(CLK_HZ / CDV_HZ_PER_D);
    localparam int PWM_STEPS = 128;
    localparam logic [11:0] PWM_STEP = 12'(PWM_CYC / PWM_STEPS);
    // buffer position
    localparam int FIFO_W = 5;
    localparam logic [4:0] FIFO_SPAN = 5'h14;
    localparam logic [4:0] FIFO_NOM = 5'h0a;
    localparam logic [4:0] CDV_OFS = 5'h02;
    localparam int CDV_W = 18;
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_STSEL = 4'h2;
    localparam logic [3:0] IDX_DIR = 4'h3;
    localparam logic [3:0] IDX_MODE = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_TARGET = 4'h9;
    localparam logic [3:0] IDX_SEL_LO = 4'hc;
    localparam logic [3:0] IDX_SEL_HI = 4'hd;
    // field positions
    localparam int DIR_BIT = 3;
    localparam int LO_OFFTRK = 0;
    localparam int LO_V3_SRC = 1;
    localparam int LO_V3_LVL = 2;
    localparam logic [3:0] HI_PHASES = 4'h0;
    // reset values
    localparam logic [3:0] RST_DIR = 4'h0;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [7:0] RST_TARGET = 8'h80;

    typedef enum logic [1:0] {
        MM_PDM = 2'b00,
        MM_PWM2 = 2'b01,
        MM_PWM4 = 2'b10,
        MM_CDV = 2'b11
    } sdf_mode_t;

    typedef struct packed {
        logic motor_drive_a;
        logic motor_drive_b;
    } sdf_motor_t;

    typedef struct packed {
        logic flex_output_three_oe;
        logic flex_output_four;
        logic flex_output_five;
        logic off_track;
    } sdf_flex_t;

    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] sel_lo;
        logic [3:0] sel_hi;
        sdf_mode_t mode;
        logic stsel;
        logic [7:0] target;
        logic [1:0] v1_sync;
        logic [1:0] v2_sync;
        logic [5:0] pdm_div;
        logic [3:0] pll_div;
        logic [11:0] pwm_cnt;
        logic [CDV_W-1:0] cdv_div;
        logic [4:0] cdv_slot;
        logic signed [7:0] cmd;
        logic [7:0] pdm_acc;
        logic [7:0] pll_acc;
        sdf_motor_t motor;
        sdf_flex_t flex;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } sdf_state_t;
endpackage : sdf_pkg

// file: logic/sdf_spindle.sv
// spindle motor drive outputs and reconfigurable pins, apb registers
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module sdf_spindle
    import sdf_pkg::*;
#(
    parameter int CDV_CYC = CDV_CYC_DEF
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // servo inputs from the decoder core
    input wire logic [FIFO_W-1:0] fifo_fill,
    input wire logic [7:0] disc_speed,
    input wire logic [7:0] pll_freq,
    input wire logic off_track_int,
    input wire logic silence_right,
    input wire logic subcode_bit,
    input wire logic deemph_flag,
    // motor pins
    output sdf_motor_t motor,
    // reconfigurable pins
    input wire logic flex_pin_one,
    input wire logic shared_flex_pin_i,
    output logic shared_flex_pin_o,
    output logic shared_flex_pin_oe,
    output logic flex_output_four,
    output logic flex_output_five,
    output logic off_track
);
    localparam logic [CDV_W-1:0] CDV_SLOT_CYC =
        CDV_W'(CDV_CYC / int'(FIFO_SPAN));

    sdf_state_t st;
    sdf_state_t next_st;

    logic [3:0] idx;
    logic mapped;
    logic wr_ok;
    logic pdm_tick;
    logic pll_tick;
    logic pwm_wrap;
    logic signed [10:0] err;
    logic [6:0] mag;
    logic [11:0] thr;
    logic acc_pwm;
    logic brk_pwm;
    logic [8:0] pdm_sum;
    logic [8:0] pll_sum;
    logic [4:0] fill_lvl;
    logic v3_level;
    logic four_val;
    logic five_val;

    assign idx = paddr[5:2];

    always_comb begin
        case (idx)
            IDX_STSEL, IDX_DIR, IDX_MODE, IDX_STATUS,
            IDX_TARGET, IDX_SEL_LO, IDX_SEL_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        if (paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    // write lands only on the edge that completes the access phase
    assign wr_ok = psel & penable & st.rdy & pwrite & mapped;

    assign pdm_tick = (st.pdm_div == 6'(PDM_CYC - 1));
    assign pll_tick = (st.pll_div == 4'(PLL_CYC - 1));
    assign pwm_wrap = (st.pwm_cnt == 12'(PWM_CYC - 1));

    // servo error: speed error plus buffer position weighted by four
    always_comb begin
        err = $signed({3'b000, st.target})
            - $signed({3'b000, disc_speed})
            + $signed({4'b0000, FIFO_NOM, 2'b00})
            - $signed({4'b0000, fifo_fill, 2'b00});
    end

    always_comb begin
        mag = st.cmd[7] ? 7'(-st.cmd) : st.cmd[6:0];
        thr = 12'(mag * PWM_STEP);
        acc_pwm = ~st.cmd[7] & (st.pwm_cnt < thr);
        brk_pwm = st.cmd[7] & (st.pwm_cnt < thr);
        // offset to unsigned so a zero command is half density
        pdm_sum = {1'b0, st.pdm_acc} + {1'b0, ~st.cmd[7], st.cmd[6:0]};
        pll_sum = {1'b0, st.pll_acc} + {1'b0, pll_freq};
        // two frames of headroom: half full (ten) reads as twelve of 20
        fill_lvl = fifo_fill + CDV_OFS;
    end

    // reconfigurable pin levels
    always_comb begin
        // silence is flagged by pulling the pin low
        v3_level = st.sel_lo[LO_V3_SRC] ? st.sel_lo[LO_V3_LVL]
                                         : ~silence_right;
        case (st.sel_hi[1:0])
            2'b01: four_val = subcode_bit;
            2'b10: four_val = 1'b0;
            2'b11: four_val = 1'b1;
            default: four_val = 1'b0;
        endcase
        case (st.sel_hi[3:2])
            2'b01: five_val = deemph_flag;
            2'b10: five_val = 1'b0;
            2'b11: five_val = 1'b1;
            default: five_val = 1'b0;
        endcase
        if (st.sel_hi == HI_PHASES) begin
            // phase legs, only live in four-line form
            four_val = (st.mode == MM_PWM4) & acc_pwm;
            five_val = (st.mode == MM_PWM4) & brk_pwm;
        end
    end

    always_comb begin
        next_st = st;

        // pin inputs pass two flops before use
        next_st.v1_sync = {st.v1_sync[0], flex_pin_one};
        next_st.v2_sync = {st.v2_sync[0], shared_flex_pin_i};

        // timebases
        next_st.pdm_div = pdm_tick ? 6'h00 : st.pdm_div + 6'h01;
        next_st.pll_div = pll_tick ? 4'h0 : st.pll_div + 4'h1;
        next_st.pwm_cnt = pwm_wrap ? 12'h000 : st.pwm_cnt + 12'h001;
        if (st.cdv_div == CDV_SLOT_CYC - 1'b1) begin
            next_st.cdv_div = '0;
            next_st.cdv_slot = (st.cdv_slot == FIFO_SPAN - 5'h01)
                ? 5'h00 : st.cdv_slot + 5'h01;
        end else begin
            next_st.cdv_div = st.cdv_div + 1'b1;
        end

        // command refreshed at the one n MHz rate
        if (st.mode == MM_CDV) begin
            next_st.cmd = 8'sh00;
        end else if (pdm_tick) begin
            if (err > 11'sd127) begin
                next_st.cmd = 8'sd127;
            end else if (err < -11'sd127) begin
                next_st.cmd = -8'sd127;
            end else begin
                next_st.cmd = err[7:0];
            end
        end

        // motor output forms
        case (st.mode)
            MM_PDM: begin
                if (pdm_tick) begin
                    next_st.pdm_acc = pdm_sum[7:0];
                    next_st.motor.motor_drive_a = pdm_sum[8];
                    next_st.motor.motor_drive_b = ~pdm_sum[8];
                end
            end
            MM_PWM2, MM_PWM4: begin
                next_st.motor.motor_drive_a = acc_pwm;
                next_st.motor.motor_drive_b = brk_pwm;
            end
            MM_CDV: begin
                next_st.motor.motor_drive_a =
                    (st.cdv_slot < fill_lvl);
                if (pll_tick) begin
                    next_st.pll_acc = pll_sum[7:0];
                    next_st.motor.motor_drive_b = pll_sum[8];
                end
            end
            default: begin
                next_st.motor = '0;
            end
        endcase

        // pin outputs, registered
        next_st.flex.flex_output_four = four_val;
        next_st.flex.flex_output_five = five_val;
        // open drain: pull low only while configured as output
        next_st.flex.flex_output_three_oe =
            st.dir[DIR_BIT] & ~v3_level;
        next_st.flex.off_track = st.sel_lo[LO_OFFTRK]
            ? st.v1_sync[1] : off_track_int;

        // apb: no wait state, answer registered in setup
        next_st.rdy = 1'b0;
        // read data only stands in the answer cycle
        next_st.rdata = 32'h0000_0000;
        if (psel & ~penable & ~st.rdy) begin
            next_st.rdy = 1'b1;
            next_st.err = ~mapped;
            next_st.rdata = 32'h0000_0000;
            case (idx)
                IDX_MODE: next_st.rdata[1:0] = st.mode;
                IDX_STSEL: next_st.rdata[0] = st.stsel;
                IDX_TARGET: next_st.rdata[7:0] = st.target;
                IDX_STATUS: begin
                    next_st.rdata[0] = st.stsel ? st.v2_sync[1]
                                                : st.v1_sync[1];
                    next_st.rdata[1] = st.v1_sync[1];
                    next_st.rdata[2] = st.v2_sync[1];
                    next_st.rdata[4:3] = st.mode;
                    next_st.rdata[5] = st.flex.off_track;
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
            if (pwrite | ~mapped) begin
                next_st.rdata = 32'h0000_0000;
            end
        end

        if (wr_ok) begin
            case (idx)
                // each register alone; direction never touches select
                IDX_DIR: next_st.dir = pwdata[3:0];
                IDX_SEL_LO: next_st.sel_lo = pwdata[3:0];
                IDX_SEL_HI: next_st.sel_hi = pwdata[3:0];
                IDX_MODE: next_st.mode = sdf_mode_t'(pwdata[1:0]);
                IDX_STSEL: next_st.stsel = pwdata[0];
                IDX_TARGET: next_st.target = pwdata[7:0];
                default: next_st.target = st.target;
            endcase
            // a mode change restarts the modulators cleanly
            if (idx == IDX_MODE) begin
                next_st.pdm_acc = 8'h00;
                next_st.pll_acc = 8'h00;
                // other forms leave the pair unrelated, restart as idle
                if (sdf_mode_t'(pwdata[1:0]) == MM_PDM) begin
                    next_st.motor.motor_drive_a = 1'b0;
                    next_st.motor.motor_drive_b = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.dir <= RST_DIR;
            st.sel_lo <= RST_SEL;
            st.sel_hi <= RST_SEL;
            st.mode <= MM_PDM;
            st.target <= RST_TARGET;
            st.motor.motor_drive_b <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.rdy & st.err;
    assign motor = st.motor;
    assign shared_flex_pin_o = 1'b0;
    assign shared_flex_pin_oe = st.flex.flex_output_three_oe;
    assign flex_output_four = st.flex.flex_output_four;
    assign flex_output_five = st.flex.flex_output_five;
    assign off_track = st.flex.off_track;
endmodule : sdf_spindle

// file: test/sdf_spindle_sva.sv
// assertion checker for the spindle drive block
`timescale 1ns/10ps
module sdf_spindle_sva
    import sdf_pkg::*;
(
    // clock, reset
    input wire logic mclk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // pins
    input wire sdf_motor_t motor,
    input wire logic shared_flex_pin_o,
    input wire logic shared_flex_pin_oe,
    input wire logic flex_output_four,
    input wire logic flex_output_five
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // shadow copies of written fields, taken from completed writes
    sdf_mode_t mode_q;
    logic dir3;
    logic [3:0] hi_q;
    sdf_motor_t mot_p;
    int gap;
    int run;
    wire wr_ok = psel && penable && pready && pwrite;
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= MM_PDM;
            dir3 <= 1'b0;
            hi_q <= 4'h0;
            gap <= 0;
            run <= 0;
        end else begin
            if (wr_ok && paddr == 8'h18) mode_q <= sdf_mode_t'(pwdata[1:0]);
            if (wr_ok && paddr == 8'h0c) dir3 <= pwdata[3];
            if (wr_ok && paddr == 8'h34) hi_q <= pwdata[3:0];
            gap <= (motor != mot_p) ? 0 : gap + 1;
            // a mode write may change the motor off the tick
            run <= (mode_q == MM_PDM && !(wr_ok && paddr == 8'h18)) ?
                run + 1 : 0;
        end
        mot_p <= motor;
    end
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_pdm_inverse: assert property (
        mode_q == MM_PDM && $past(mode_q) == MM_PDM
        |-> motor.motor_drive_a != motor.motor_drive_b)
        else $error("drive b not inverse of a");
    a_pdm_tick: assert property (
        $changed(motor) && run > gap + 2 |-> (gap + 1) % PDM_CYC == 0)
        else $error("motor change off the tick");
    a_open_drain: assert property (
        1'b1 |-> !shared_flex_pin_o &&
        (!shared_flex_pin_oe || dir3 || $past(dir3)))
        else $error("shared pin driven while input");
    a_legs_apart: assert property (
        mode_q == MM_PWM4 && $past(mode_q) == MM_PWM4
        |-> !(flex_output_four && flex_output_five))
        else $error("both legs on");
    a_four_const: assert property (
        hi_q == $past(hi_q) && hi_q[1] |-> flex_output_four == hi_q[0])
        else $error("pin four constant wrong");
    a_five_const: assert property (
        hi_q == $past(hi_q) && hi_q[3] |-> flex_output_five == hi_q[2])
        else $error("pin five constant wrong");
    c_cdv: cover property (mode_q == MM_CDV && motor.motor_drive_a);
    c_pwm4: cover property (mode_q == MM_PWM4 && flex_output_four);
    c_pin: cover property (shared_flex_pin_oe);
endmodule : sdf_spindle_sva

// file: test/sdf_bridge.sv
// motor bridge legs and shared pin pull-up on the far side
`timescale 1ns/10ps
module sdf_bridge (
    // from the block
    input wire logic mclk,
    input wire logic pin_oe,
    input wire logic leg_c,
    input wire logic leg_d,
    // shared pin
    input wire logic ext_low,
    output logic pin_level,
    output int overlap
);
    // pull-up wins unless a party sinks the line
    assign pin_level = !(pin_oe || ext_low);
    // shoot-through would burn the bridge, so count it
    initial overlap = 0;
    always @(posedge mclk) begin
        if (leg_c && leg_d) overlap <= overlap + 1;
    end
endmodule : sdf_bridge

// file: test/tb_top.sv
// self-checking bench for the spindle drive block
`timescale 1ns/10ps
module tb_top
    import sdf_pkg::*;
;
    localparam int CDV_T = 200;
    logic mclk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, speed = 8'h80, pll = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] fill = 5'h0a;
    logic otk_i = 0, sil = 0, subc = 0, deem = 0, pin1 = 0, ext_low = 0;
    logic pready, pslverr, er, pin_lvl, pin_o, pin_oe, four, five, otk;
    sdf_motor_t motor;
    int bad_count = 0, cmp_count = 0, overlap, na, nb, nc, nd;
    always #10 mclk = ~mclk;
    sdf_spindle #(.CDV_CYC(CDV_T)) uut (
        .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_fill(fill),
        .disc_speed(speed), .pll_freq(pll), .off_track_int(otk_i),
        .silence_right(sil), .subcode_bit(subc), .deemph_flag(deem),
        .motor(motor), .flex_pin_one(pin1), .shared_flex_pin_i(pin_lvl),
        .shared_flex_pin_o(pin_o), .shared_flex_pin_oe(pin_oe),
        .flex_output_four(four), .flex_output_five(five), .off_track(otk));
    sdf_bridge bridge (.mclk(mclk), .pin_oe(pin_oe), .leg_c(four),
        .leg_d(five), .ext_low(ext_low), .pin_level(pin_lvl),
        .overlap(overlap));
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task rng(input int v, input int lo, input int hi);
        chk(v >= lo && v <= hi, 1'b1);
        if (v < lo || v > hi) $display("count %h not near %h", v, lo);
    endtask : rng
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            bad_count++;
            finish_test;
        end
    endtask : apb
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk(er, ee);
    endtask : rdc
    task cnt(input int n);
        {na, nb, nc, nd} = '0;
        repeat (n) begin
            @(posedge mclk);
            na += motor.motor_drive_a;
            nb += motor.motor_drive_b;
            nc += four;
            nd += five;
        end
    endtask : cnt
    task t_regs;
        chk(pin_oe, 1'b0);
        rdc(8'h0c, 32'h0, 1'b0);
        rdc(8'h3c, 32'h0, 1'b1);
        rdc(8'h18, 32'h0, 1'b0);
        rdc(8'h24, {24'h0, RST_TARGET}, 1'b0);
        apb(1'b1, 8'h20, 32'hff);
        rdc(8'h20, 32'h4, 1'b0);
        pin1 <= 1'b1;
        repeat (4) @(posedge mclk);
        rdc(8'h20, 32'h7, 1'b0);
        chk(otk, 1'b0);
        apb(1'b1, 8'h08, 32'h1);
        ext_low <= 1'b1;
        repeat (4) @(posedge mclk);
        rdc(8'h20, 32'h2, 1'b0);
        apb(1'b1, 8'h30, 32'h1);
        repeat (3) @(posedge mclk);
        chk(otk, 1'b1);
        {pin1, ext_low} <= 2'b00;
        apb(1'b1, 8'h30, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task t_pdm;
        for (int i = 0; i < 3; i++) begin
            speed <= (i == 0) ? 8'h80 : (i == 1) ? 8'h60 : 8'ha0;
            repeat (200) @(posedge mclk);
            cnt(1000);
            chk(na + nb, 1000);
            if (i == 0) rng(na, 450, 550);
            if (i == 1) rng(na, 551, 1000);
            if (i == 2) rng(na, 0, 449);
        end
        // clock enable low freezes the modulator for two ticks
        ce <= 1'b0;
        cnt(100);
        chk(na % 100, 0);
        chk(na + nb, 100);
        ce <= 1'b1;
        $display("test pdm done");
    endtask : t_pdm
    task t_pwm;
        int hi, o;
        hi = 64 * PWM_STEP;
        o = overlap;
        apb(1'b1, 8'h34, 32'h0);
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, 8'h18, m);
            for (int i = 0; i < 2; i++) begin
                speed <= i ? 8'ha0 : 8'h60;
                repeat (PWM_CYC) @(posedge mclk);
                cnt(2 * PWM_CYC);
                if (m == 1) rng(i ? nb : na, hi - 4, hi + 4);
                if (m == 1) chk(i ? na : nb, 0);
                if (m == 2) rng(i ? nd : nc, hi - 4, hi + 4);
                if (m == 2) chk(i ? nc : nd, 0);
            end
        end
        chk(overlap - o, 0);
        $display("test pwm done");
    endtask : t_pwm
    task t_cdv;
        apb(1'b1, 8'h18, 32'h3);
        pll <= 8'h80;
        for (int k = 0; k < 3; k++) begin
            fill <= (k == 2) ? 5'h00 : FIFO_NOM;
            speed <= (k == 1) ? 8'h20 : 8'h60;
            repeat (CDV_T) @(posedge mclk);
            cnt(2 * CDV_T);
            // slots lit are fill plus two of twenty
            rng(na, (k == 2) ? 38 : 238, (k == 2) ? 42 : 242);
        end
        cnt(2816);
        rng(nb, 1364, 1452);
        {fill, speed, pll} <= {FIFO_NOM, 16'h8000};
        apb(1'b1, 8'h18, 32'h0);
        $display("test cdv done");
    endtask : t_cdv
    task t_flex;
        logic [3:0] c;
        logic v;
        apb(1'b1, 8'h30, 32'h2);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h0c, i == 1 ? 32'h0 : 32'h8);
            repeat (3) @(posedge mclk);
            chk(pin_oe, i != 1);
        end
        apb(1'b1, 8'h30, 32'h6);
        repeat (3) @(posedge mclk);
        chk(pin_oe, 1'b0);
        apb(1'b1, 8'h30, 32'h0);
        sil <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(pin_oe, 1'b1);
        sil <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(pin_oe, 1'b0);
        for (int i = 0; i < 10; i++) begin
            c = (i < 2) ? 4'h5 : (i < 4) ? 4'ha : (i < 6) ? 4'hf : (i < 8) ?
                4'h6 : 4'h9;
            v = i[0];
            {subc, deem} <= {v, v};
            apb(1'b1, 8'h34, c);
            repeat (3) @(posedge mclk);
            chk(four, (c[1:0] == 2'b01) ? v : c[0]);
            chk(five, (c[3:2] == 2'b01) ? v : c[2]);
        end
        $display("test flex done");
    endtask : t_flex
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_pdm;
        t_pwm;
        t_cdv;
        t_flex;
        finish_test;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        finish_test;
    end
endmodule : tb_top
bind sdf_spindle sdf_spindle_sva chk_i (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .motor(motor),
    .shared_flex_pin_o(shared_flex_pin_o),
    .shared_flex_pin_oe(shared_flex_pin_oe),
    .flex_output_four(flex_output_four),
    .flex_output_five(flex_output_five));
